// ===== rtl/ppfc_consts.vh
// register map, field positions and reset values of the port function block
`ifndef PPFC_CONSTS_VH
`define PPFC_CONSTS_VH
// ==========================================================================
// register byte offsets
`define PPFC_OFF_DATA     8'h00
`define PPFC_OFF_DIR      8'h04
`define PPFC_OFF_AMODE    8'h08
`define PPFC_OFF_MISC     8'h0C
`define PPFC_OFF_ACH      8'h10
`define PPFC_OFF_PIN      8'h14
// ==========================================================================
// field positions
`define PPFC_MISC_OD_BIT  2
`define PPFC_MISC_PU_BIT  3
`define PPFC_AMODE_G4_BIT 12
`define PPFC_AMODE_SO_BIT 13
// ==========================================================================
// reset values
`define PPFC_DATA_RST     16'hFFFF
`define PPFC_DIR_RST      16'h0000
`define PPFC_AMODE_RST    4'h0
`define PPFC_MISC_RST     4'h0
`define PPFC_ACH_RST      4'h0
`define PPFC_RESP_OKAY    2'b00
`define PPFC_RESP_SLVERR  2'b10
`endif

// ===== rtl/ppfc_port_ctrl.v
// port pin function and output buffer control with an axi4-lite slave
// Function
// RULE_01: group4 select makes all four pins analog
// RULE_02: group8 pins follow own direction bit only
// RULE_03: open-drain select kills serial pin pmos
// RULE_04: analog select leaves active pull-up on
// RULE_05: port data bits reset to one
// RULE_06: software clears data before pull-up off
// RULE_07: analog mode turns both buffer transistors off
// RULE_08: converter channel from channel select register
// RULE_09: output drives data, input leaves buffer off
// RULE_10: group2 open drain low only dir1 data0
// RULE_11: software keeps unused pins at reset
// RULE_12: pull-up on when enabled and data one
// RULE_13: pull-up enable zero turns all off
// RULE_14: misc register cleared on reset and stop
// RULE_15: direction and analog bits reset to zero
`include "ppfc_consts.vh"
module ppfc_port_ctrl (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // stop mode entry
  input  wire        stop_mode,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // serial output from the serial unit
  input  wire        serial_out_data,
  // pins: [3:0] group4, [7:4] group8, [11:8] group2, [12] serial pin
  input  wire [12:0] pin_in,
  output wire [12:0] pin_out,
  output wire [12:0] pin_oe_n,
  output wire [12:0] pmos_on,
  output wire [12:0] nmos_on,
  output wire [12:0] pullup_on,
  // converter routing
  output wire [3:0]  analog_channel_sel,
  output wire [3:0]  group4_analog_en
);

  // ========================================================================
  // registers
  // data/dir bit map: [3:0] group4, [7:4] group8, [11:8] group2, [12] so pin
  reg  [15:0] port_data_bits_q;
  reg  [15:0] direction_control_bits_q;
  reg         group4_analog_select_q;
  reg         serial_out_pin_select_q;
  reg  [3:0]  misc_control_reg_q;
  reg  [3:0]  analog_channel_select_reg_q;
  reg  [12:0] pin_sample_q;

  wire        so_open_drain_select  = misc_control_reg_q[`PPFC_MISC_OD_BIT];
  wire        global_pullup_enable  = misc_control_reg_q[`PPFC_MISC_PU_BIT];
  wire [3:0]  group4_direction_bits = direction_control_bits_q[3:0];
  wire [3:0]  group8_direction_bits = direction_control_bits_q[7:4];

  // ========================================================================
  // axi4-lite slave: address and data taken in either order
  reg         aw_held_q;
  reg  [7:0]  aw_addr_q;
  reg         w_held_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;

  // one write in flight: both readies drop while bvalid stands
  // bresp tells an unmapped write apart; the registers ignore it
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  wire        aw_fire = s_axi_awvalid && s_axi_awready;
  wire        w_fire  = s_axi_wvalid && s_axi_wready;
  wire        aw_have = aw_held_q || aw_fire;
  wire        w_have  = w_held_q || w_fire;
  wire [7:0]  wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
  wire        wr_go   = aw_have && w_have && !bvalid_q;
  wire        wr_ok   = (wr_addr == `PPFC_OFF_DATA) ||
                        (wr_addr == `PPFC_OFF_DIR) ||
                        (wr_addr == `PPFC_OFF_AMODE) ||
                        (wr_addr == `PPFC_OFF_MISC) ||
                        (wr_addr == `PPFC_OFF_ACH) ||
                        (wr_addr == `PPFC_OFF_PIN);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `PPFC_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_ok ? `PPFC_RESP_OKAY : `PPFC_RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_held_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
          bvalid_q <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // register writes; only byte lanes 0 and 1 hold bits
  wire wr_b0 = wr_go && wr_strb[0];
  wire wr_b1 = wr_go && wr_strb[1];

  reg  [15:0] port_data_bits_d;
  reg  [15:0] direction_control_bits_d;
  reg         group4_analog_select_d;
  reg         serial_out_pin_select_d;
  reg  [3:0]  misc_control_reg_d;
  reg  [3:0]  analog_channel_select_reg_d;

  always @* begin
    // defaults keep every register as it is
    port_data_bits_d            = port_data_bits_q;
    direction_control_bits_d    = direction_control_bits_q;
    group4_analog_select_d      = group4_analog_select_q;
    serial_out_pin_select_d     = serial_out_pin_select_q;
    misc_control_reg_d          = misc_control_reg_q;
    analog_channel_select_reg_d = analog_channel_select_reg_q;
    if (wr_b0 && wr_addr == `PPFC_OFF_DATA) begin
      port_data_bits_d[7:0] = wr_data[7:0];
    end
    if (wr_b1 && wr_addr == `PPFC_OFF_DATA) begin
      port_data_bits_d[15:8] = {3'b000, wr_data[12:8]};
    end
    if (wr_b0 && wr_addr == `PPFC_OFF_DIR) begin
      direction_control_bits_d[7:0] = wr_data[7:0];
    end
    if (wr_b1 && wr_addr == `PPFC_OFF_DIR) begin
      direction_control_bits_d[15:8] = {3'b000, wr_data[12:8]};
    end
    if (wr_b1 && wr_addr == `PPFC_OFF_AMODE) begin
      group4_analog_select_d  = wr_data[`PPFC_AMODE_G4_BIT];
      serial_out_pin_select_d = wr_data[`PPFC_AMODE_SO_BIT];
    end
    // stop entry wins over a write in the same cycle
    if (stop_mode) begin
      misc_control_reg_d = `PPFC_MISC_RST;  // [RULE_14]
    end else if (wr_b0 && wr_addr == `PPFC_OFF_MISC) begin
      misc_control_reg_d = wr_data[3:0];
    end
    // channel select only steers the converter mux
    if (wr_b0 && wr_addr == `PPFC_OFF_ACH) begin
      analog_channel_select_reg_d = wr_data[3:0];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      port_data_bits_q            <= `PPFC_DATA_RST;  // [RULE_05]
      direction_control_bits_q    <= `PPFC_DIR_RST;   // [RULE_15]
      group4_analog_select_q      <= 1'b0;            // [RULE_15]
      serial_out_pin_select_q     <= 1'b0;
      misc_control_reg_q          <= `PPFC_MISC_RST;  // [RULE_14]
      analog_channel_select_reg_q <= `PPFC_ACH_RST;
    end else begin
      port_data_bits_q            <= port_data_bits_d;
      direction_control_bits_q    <= direction_control_bits_d;
      group4_analog_select_q      <= group4_analog_select_d;
      serial_out_pin_select_q     <= serial_out_pin_select_d;
      misc_control_reg_q          <= misc_control_reg_d;
      analog_channel_select_reg_q <= analog_channel_select_reg_d;
    end
  end

  // ========================================================================
  // read channel; the pin sample is a plain clocked copy of the pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_sample_q <= 13'h0000;
    end else begin
      pin_sample_q <= pin_in;
    end
  end

  // reads never change state, so a read beside a write is safe
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= `PPFC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `PPFC_RESP_OKAY;
      case (s_axi_araddr)
        `PPFC_OFF_DATA:  rdata_q <= {16'h0000, port_data_bits_q};
        `PPFC_OFF_DIR:   rdata_q <= {16'h0000, direction_control_bits_q};
        `PPFC_OFF_AMODE: rdata_q <= {18'h0_0000, serial_out_pin_select_q,
                                     group4_analog_select_q, 12'h000};
        `PPFC_OFF_MISC:  rdata_q <= {28'h000_0000, misc_control_reg_q};
        `PPFC_OFF_ACH:   rdata_q <= {28'h000_0000,
                                     analog_channel_select_reg_q};
        `PPFC_OFF_PIN:   rdata_q <= {19'h0_0000, pin_sample_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `PPFC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ========================================================================
  // pin buffer control
  genvar i;
  generate
    for (i = 0; i < 13; i = i + 1) begin : g_pin
      // buffers are combinational from the registers
      wire d   = port_data_bits_q[i];
      wire dir = direction_control_bits_q[i];
      if (i < 4) begin : g_grp4
        // analog select overrides direction, buffer isolated
        wire ana = group4_analog_select_q;                  // [RULE_01]
        wire drv = !ana && group4_direction_bits[i];        // [RULE_07]
        assign pmos_on[i]   = drv && d;                     // [RULE_09]
        assign nmos_on[i]   = drv && !d;                    // [RULE_09]
        assign pin_out[i]   = d;
        // pull-up ignores analog selection on purpose
        assign pullup_on[i] = global_pullup_enable && d;    // [RULE_04]
        assign group4_analog_en[i] = ana;
      end else if (i < 8) begin : g_grp8
        // high-voltage group: no pull-up, no shared function
        wire drv = group8_direction_bits[i-4];              // [RULE_02]
        assign pmos_on[i]   = drv && d;
        assign nmos_on[i]   = drv && !d;
        assign pin_out[i]   = d;
        assign pullup_on[i] = 1'b0;
      end else if (i < 12) begin : g_grp2
        // medium-voltage open drain: only low is driven
        // direction 0 or data 1 leaves the pin floating
        assign pmos_on[i]   = 1'b0;
        assign nmos_on[i]   = dir && !d;                    // [RULE_10]
        assign pin_out[i]   = 1'b0;
        assign pullup_on[i] = 1'b0;
      end else begin : g_so
        // serial function drives regardless of direction bit
        // open drain applies in both pin functions
        wire val = serial_out_pin_select_q ? serial_out_data : d;
        wire drv = serial_out_pin_select_q || dir;          // [RULE_09]
        assign pmos_on[i]   = drv && val && !so_open_drain_select; // [RULE_03]
        assign nmos_on[i]   = drv && !val;
        assign pin_out[i]   = val;
        assign pullup_on[i] = global_pullup_enable && d;    // [RULE_12]
      end
      assign pin_oe_n[i] = !(pmos_on[i] || nmos_on[i]);
    end
  endgenerate
  // pull-ups of group 4 and the serial pin fall with the enable  [RULE_13]

  // converter routing is independent of the buffer isolation bits
  assign analog_channel_sel = analog_channel_select_reg_q;  // [RULE_08]

endmodule

// ===== tb/ppfc_pad_model.sv
// pad model: resolves pin levels from buffer and pull-up state
module ppfc_pad_model (
  // clock
  input  wire logic        aclk,
  // buffer state from the block
  input  wire logic [12:0] pmos_on,
  input  wire logic [12:0] nmos_on,
  input  wire logic [12:0] pullup_on,
  // resolved pin levels
  output logic      [12:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // pad resolution
  logic [12:0] float_q = 13'h0a5a;
  // undriven pins wander every cycle so a stale level never reads as valid
  always @(posedge aclk) float_q <= ~float_q;
  // pmos wins, then nmos, then the pull-up, else the floating level
  assign pin_in = pmos_on | (~nmos_on & (pullup_on | float_q));
endmodule

// ===== tb/ppfc_port_ctrl_assertions.sv
// assertion checker for the port function block
module ppfc_port_ctrl_assertions (
  // clock, reset and stop mode entry
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        stop_mode,
  // buffer and routing state
  input wire logic [12:0] pmos_on,
  input wire logic [12:0] nmos_on,
  input wire logic [12:0] pullup_on,
  input wire logic [12:0] pin_oe_n,
  input wire logic [3:0]  group4_analog_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // checks
  sequence s_stop;
    stop_mode ##1 1'b1;
  endsequence
  a_g4_same:
    assert property (group4_analog_en == {4{group4_analog_en[0]}})
    else $error("group4 enables differ");
  a_g4_hiz:
    assert property (group4_analog_en[0] |->
                     (pmos_on[3:0] | nmos_on[3:0]) == 4'h0)
    else $error("analog pin buffer on");
  a_g2_no_pmos:
    assert property (pmos_on[11:8] == 4'h0)
    else $error("open drain pin pmos on");
  a_drive_excl:
    assert property ((pmos_on & nmos_on) == 13'h0000)
    else $error("pmos and nmos both on");
  a_oe_follows:
    assert property (pin_oe_n == ~(pmos_on | nmos_on))
    else $error("enable does not follow buffer");
  a_pull_groups:
    assert property (pullup_on[11:4] == 8'h00)
    else $error("pull-up on pin without one");
  a_reset_quiet:
    assert property ($rose(aresetn) |->
                     (pullup_on | pmos_on | nmos_on) == 13'h0000)
    else $error("pins active after reset");
  a_stop_pull:
    assert property (s_stop |-> pullup_on == 13'h0000)
    else $error("pull-up on after stop");
endmodule

bind ppfc_port_ctrl ppfc_port_ctrl_assertions u_chk (
  .aclk(aclk), .aresetn(aresetn), .stop_mode(stop_mode),
  .pmos_on(pmos_on), .nmos_on(nmos_on), .pullup_on(pullup_on),
  .pin_oe_n(pin_oe_n), .group4_analog_en(group4_analog_en));

// ===== tb/tb.sv
// self-checking testbench for the port function block
`include "ppfc_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  logic        aclk, aresetn, stop_mode, ser;
  logic [7:0]  aw, ar;
  logic [31:0] wd, rd, q, x;
  logic        awv, awr, wv, wr, bv, bq, arv, arr, rv, rq;
  logic [1:0]  bp, rp, r;
  logic [12:0] pin, pm, nm, pu, po, oen;
  logic [3:0]  ws;
  logic [3:0]  ach, g4;
  logic [46:0] e;
  int          fails, compares, seed, k, i;
  int          m[5];
  int          off[5] = '{`PPFC_OFF_DATA, `PPFC_OFF_DIR,
                          `PPFC_OFF_AMODE, `PPFC_OFF_MISC, `PPFC_OFF_ACH};
  int          msk[5] = '{32'h0000_1fff, 32'h0000_1fff, 32'h0000_3000,
                          32'h0000_000f, 32'h0000_000f};
  ppfc_port_ctrl dut (.aclk(aclk), .aresetn(aresetn), .stop_mode(stop_mode),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bp), .s_axi_bvalid(bv),
    .s_axi_bready(bq), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rp),
    .s_axi_rvalid(rv), .s_axi_rready(rq), .serial_out_data(ser),
    .pin_in(pin), .pin_out(po), .pin_oe_n(oen), .pmos_on(pm), .nmos_on(nm),
    .pullup_on(pu), .analog_channel_sel(ach), .group4_analog_en(g4));
  ppfc_pad_model pad (.aclk(aclk), .pmos_on(pm), .nmos_on(nm),
    .pullup_on(pu), .pin_in(pin));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ==========================================================================
  // tasks and model
  task automatic results();
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // handshake values are stable from the negedge up to the taking edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr, dn;
    @(posedge aclk);
    aw <= a;
    ar <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    bq <= w;
    arv <= !w;
    rq <= !w;
    dn = 1'b0;
    while (!dn) begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wr;
      tr = arv && arr;
      dn = w ? bv : rv;
      r = w ? bp : rp;
      q = rd;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tr) arv <= 1'b0;
    end
    bq <= 1'b0;
    rq <= 1'b0;
  endtask
  function automatic logic [46:0] model();
    logic [12:0] p, n, u, d, c;
    logic v, o;
    d = m[0][12:0];
    c = m[1][12:0];
    p = c & d;
    n = c & ~d;
    if (m[2][12]) begin
      p[3:0] = 4'h0;
      n[3:0] = 4'h0;
    end
    p[11:8] = 4'h0;
    o = m[2][13] | c[12];
    v = m[2][13] ? ser : d[12];
    p[12] = o & v & !m[3][2];
    n[12] = o & !v;
    u = m[3][3] ? d & 13'h100f : 13'h0000;
    return {{4{m[2][12]}}, m[4][3:0], u, n, p};
  endfunction
  task automatic chk_pins();
    logic [46:0] t;
    @(negedge aclk);
    t = model();
    cmp({g4, ach, pu, nm, pm}, t);
    cmp({po & ~oen, ~oen}, {t[12:0], t[12:0] | t[25:13]});
  endtask
  task automatic put(input int j, input logic [31:0] d);
    bus(1'b1, off[j][7:0], d);
    cmp(r, `PPFC_RESP_OKAY);
    m[j] = d & msk[j];
    chk_pins();
    bus(1'b0, off[j][7:0], 32'h0000_0000);
    cmp(q & msk[j], m[j]);
  endtask
  // ==========================================================================
  // sequence
  initial begin
    seed = 32'h0000_ef3e;
    {aresetn, stop_mode, ser, awv, wv, bq, arv, rq} = 8'h00;
    {aw, ar, wd} = 48'h0000_0000_0000;
    ws = 4'hf;
    m = '{32'h0000_1fff, 0, 0, 0, 0};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 5; k++) begin
      bus(1'b0, off[k][7:0], 32'h0000_0000);
      cmp(q & msk[k], m[k]);
    end
    chk_pins();
    // pull-up kept under analog select, then switched off safely
    put(3, 32'h0000_0008);
    put(2, 32'h0000_1000);
    put(0, 32'h0000_1ff0);
    put(3, 32'h0000_0000);
    // serial pin as port and as serial output, open drain
    put(1, 32'h0000_1000);
    put(3, 32'h0000_0004);
    put(0, 32'h0000_1fff);
    put(2, 32'h0000_2000);
    put(3, 32'h0000_000c);
    @(posedge aclk);
    stop_mode <= 1'b1;
    @(posedge aclk);
    stop_mode <= 1'b0;
    m[3] = 0;
    chk_pins();
    bus(1'b0, `PPFC_OFF_MISC, 32'h0000_0000);
    cmp(q, 32'h0000_0000);
    // a write without lane 0 must leave the misc register alone
    ws <= 4'h2;
    bus(1'b1, `PPFC_OFF_MISC, 32'h0000_000f);
    ws <= 4'hf;
    cmp(r, `PPFC_RESP_OKAY);
    chk_pins();
    bus(1'b1, 8'h18, 32'hffff_ffff);
    cmp(r, `PPFC_RESP_SLVERR);
    bus(1'b0, 8'h18, 32'h0000_0000);
    cmp({r, q}, {`PPFC_RESP_SLVERR, 32'h0000_0000});
    for (i = 0; i < 60; i++) begin
      k = $unsigned($random(seed)) % 5;
      x = $random(seed);
      ser <= x[0];
      put(k, $random(seed));
      bus(1'b0, `PPFC_OFF_PIN, 32'h0000_0000);
      e = model();
      x = {19'h0_0000, e[12:0] | e[25:13] | e[38:26]};
      cmp(q[12:0] & x[12:0], e[12:0] | (e[38:26] & ~e[25:13]));
    end
    results();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    results();
  end
endmodule
